// File: src/igc_pkg.sv
// constants for the input gain control and reset block
package igc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned EXT_NOM_US = 50;
  localparam int unsigned EXT_MAX_US = 100;
  // nominal extension, kept below the maximum
  localparam int unsigned EXT_CYCLES = EXT_NOM_US * (CLK_HZ / 1_000_000);
  localparam int unsigned EXT_MAX_CYCLES = EXT_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned EXT_W = 11;
  // timeout in slow timer ticks: waits 3 edges, so 2..3 whole periods after an arbitrary phase
  localparam logic [1:0] TIMEOUT_TICKS = 2'h3;
  localparam int unsigned GAIN_W = 6;
  localparam logic [5:0] GAIN_MAX = 6'h3F;
  // reset value 0 dB: code 16
  localparam logic [5:0] GAIN_RST = 6'h10;
  localparam logic GAIN_REG_MUTE_RST = 1'b0;
  localparam logic GAIN_REG_ZC_RST = 1'b0;
  localparam logic TIMEOUT_EN_RST = 1'b0;
  // input select reset: plus and minus mic connected, line off
  localparam logic [2:0] INSEL_RST = 3'h3;
  localparam logic [1:0] AMP_PWR_RST = 2'h0;
  localparam logic [1:0] BOOST_PWR_RST = 2'h0;
  localparam logic [1:0] ALC_EN_RST = 2'h0;
  localparam int unsigned SEL_MIC_PLUS = 0;
  localparam int unsigned SEL_MIC_MINUS = 1;
  localparam int unsigned SEL_LINE = 2;
  // register addresses on the control port
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
  localparam logic [6:0] ADDR_INPUT_POWER = 7'h02;
  localparam logic [6:0] ADDR_ZC_TIMEOUT = 7'h07;
  localparam logic [6:0] ADDR_LEVEL_CTRL = 7'h20;
  localparam logic [6:0] ADDR_INPUT_SELECT = 7'h2C;
  localparam logic [6:0] ADDR_LEFT_GAIN = 7'h2D;
  localparam logic [6:0] ADDR_RIGHT_GAIN = 7'h2E;
  // field positions in the 9-bit data word
  localparam int unsigned F_GAIN_LSB = 0;
  localparam int unsigned F_MUTE = 6;
  localparam int unsigned F_ZC = 7;
  localparam int unsigned F_UPDATE = 8;
  localparam int unsigned F_TIMEOUT_EN = 0;
  localparam int unsigned F_AMP_PWR_LSB = 2;
  localparam int unsigned F_BOOST_PWR_LSB = 4;
  localparam int unsigned F_ALC_EN_LSB = 7;
  localparam int unsigned F_INSEL_L_LSB = 0;
  localparam int unsigned F_INSEL_R_LSB = 4;
  localparam logic [2:0] RST_GUARD_RST = 3'h7;
  typedef enum logic [1:0] {
    IGC_ST_HOLD = 2'b00,
    IGC_ST_EXTEND = 2'b01,
    IGC_ST_RUN = 2'b10
  } igc_state_t;
endpackage : igc_pkg

// File: src/igc_top.sv
// input gain amplifier control with power-on and software reset
// Function
// (R01) low supply holds reset, registers default
// (R02) control accesses ignored during reset
// (R03) extend reset about 50us, max 100us
// (R04) supply drop restarts reset and extension
// (R05) no reset status bit readable
// (R06) host polls non-default write for reset end
// (R07) host issues software reset after power-on
// (R08) host keeps test bit to detect resets
// (R09) write to address 0 resets registers
// (R10) other register write ends software reset
// (R11) three selectable sources per amplifier
// (R12) gain -12dB to +35.25dB, 0.75dB steps
// (R13) path needs amp and boost power
// (R14) per-channel gain, mute, update, zero-cross
// (R15) update bit is write-only
// (R16) update zero stores pending gain
// (R17) update one applies both channels together; code skips a channel under level control
// (R18) level control adjusts gain itself
// (R19) host avoids gain writes under level control
// (R20) zero-cross enable waits for crossing
// (R21) zero-cross off applies immediately
// (R22) timeout applies after 2.5-3.5 slow ticks; code applies on the third tick edge, 2-3 ticks
// (R23) mute silences output, gain kept
module igc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic analog_supply_ok,
  input wire logic core_supply_ok,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [6:0] wr_addr,
  input wire logic [8:0] wr_data,
  input wire logic [6:0] rd_addr,
  output logic [8:0] rd_data,
  input wire logic [1:0] zero_cross,
  input wire logic slow_tick,
  input wire logic [1:0] alc_gain_vld,
  input wire logic [5:0] alc_gain_l,
  input wire logic [5:0] alc_gain_r,
  output logic [5:0] gain_l_out,
  output logic [5:0] gain_r_out,
  output logic [1:0] amp_mute,
  output logic [2:0] sel_l,
  output logic [2:0] sel_r,
  output logic [1:0] path_pass,
  output logic [1:0] alc_enable
);
  logic [1:0] a_sync_ff, c_sync_ff, zc0_ff, zc1_ff;
  logic [1:0] tk_sync_ff;
  logic tk_prev_ff;
  igc_pkg::igc_state_t state_ff, nxt_state;
  logic [10:0] ext_cnt_ff;
  logic int_rst;
  logic soft_rst_ff;
  logic reg_rst;
  logic wr_ok;
  logic [5:0] stored_ff [2];
  logic [5:0] active_ff [2];
  logic [1:0] pend_ff, trig_ff, mute_ff, zc_en_ff;
  logic timeout_en_ff;
  logic [1:0] amp_pwr_ff, boost_pwr_ff, alc_en_ff;
  logic [2:0] insel_ff [2];
  logic [1:0] tmo_cnt_ff [2];
  logic [1:0] wr_gain, wr_upd, apply;
  logic tick_rise;

  // two-flop sync of pins
  always_ff @(posedge core_clk) begin
    a_sync_ff <= {a_sync_ff[0], analog_supply_ok};
    c_sync_ff <= {c_sync_ff[0], core_supply_ok};
    tk_sync_ff <= {tk_sync_ff[0], slow_tick};
    zc0_ff <= {zc0_ff[0], zero_cross[0]};
    zc1_ff <= {zc1_ff[0], zero_cross[1]};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tk_prev_ff <= 1'b0;
    end else begin
      tk_prev_ff <= tk_sync_ff[1];
    end
  end
  assign tick_rise = tk_sync_ff[1] & ~tk_prev_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      igc_pkg::IGC_ST_HOLD: if (a_sync_ff[1] && c_sync_ff[1]) nxt_state = igc_pkg::IGC_ST_EXTEND;
      igc_pkg::IGC_ST_EXTEND: if (ext_cnt_ff == 11'(igc_pkg::EXT_CYCLES - 1)) nxt_state = igc_pkg::IGC_ST_RUN;
      igc_pkg::IGC_ST_RUN: nxt_state = igc_pkg::IGC_ST_RUN;
      default: nxt_state = igc_pkg::IGC_ST_HOLD;
    endcase
    // (R04) drop restarts reset
    if (!(a_sync_ff[1] && c_sync_ff[1])) nxt_state = igc_pkg::IGC_ST_HOLD;
  end

  // (R03) extension timer count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= igc_pkg::IGC_ST_HOLD;
      ext_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ext_cnt_ff <= (state_ff == igc_pkg::IGC_ST_EXTEND && nxt_state == igc_pkg::IGC_ST_EXTEND) ?
        ext_cnt_ff + 11'h001 : 11'h000;
    end
  end

  // (R01) internal reset from supplies
  assign int_rst = rst | (state_ff != igc_pkg::IGC_ST_RUN);
  // (R02) gate accesses during reset
  assign wr_ok = wr_stb & ~int_rst;

  // (R09) address 0 write starts reset
  always_ff @(posedge core_clk) begin
    if (int_rst) begin
      soft_rst_ff <= 1'b0;
    end else if (wr_ok) begin
      // (R10) other write ends reset
      soft_rst_ff <= (wr_addr == igc_pkg::ADDR_SOFT_RESET);
    end
  end
  // (R10) defaults held until other write
  assign reg_rst = int_rst | (wr_ok & (wr_addr == igc_pkg::ADDR_SOFT_RESET)) | (soft_rst_ff & ~wr_ok);

  assign wr_gain[0] = wr_ok & (wr_addr == igc_pkg::ADDR_LEFT_GAIN);
  assign wr_gain[1] = wr_ok & (wr_addr == igc_pkg::ADDR_RIGHT_GAIN);
  assign wr_upd = wr_gain & {2{wr_data[igc_pkg::F_UPDATE]}};

  // control registers
  always_ff @(posedge core_clk) begin
    if (reg_rst) begin
      timeout_en_ff <= igc_pkg::TIMEOUT_EN_RST;
      amp_pwr_ff <= igc_pkg::AMP_PWR_RST;
      boost_pwr_ff <= igc_pkg::BOOST_PWR_RST;
      alc_en_ff <= igc_pkg::ALC_EN_RST;
      insel_ff[0] <= igc_pkg::INSEL_RST;
      insel_ff[1] <= igc_pkg::INSEL_RST;
    end else if (wr_ok) begin
      if (wr_addr == igc_pkg::ADDR_ZC_TIMEOUT) timeout_en_ff <= wr_data[igc_pkg::F_TIMEOUT_EN];
      if (wr_addr == igc_pkg::ADDR_INPUT_POWER) begin
        amp_pwr_ff <= wr_data[igc_pkg::F_AMP_PWR_LSB +: 2];
        boost_pwr_ff <= wr_data[igc_pkg::F_BOOST_PWR_LSB +: 2];
      end
      if (wr_addr == igc_pkg::ADDR_LEVEL_CTRL) alc_en_ff <= wr_data[igc_pkg::F_ALC_EN_LSB +: 2];
      if (wr_addr == igc_pkg::ADDR_INPUT_SELECT) begin
        insel_ff[0] <= wr_data[igc_pkg::F_INSEL_L_LSB +: 3];
        insel_ff[1] <= wr_data[igc_pkg::F_INSEL_R_LSB +: 3];
      end
    end
  end

  // per-channel gain logic
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic zc_seen;
    assign zc_seen = (ch == 0) ? zc0_ff[1] : zc1_ff[1];
    // (R20) (R21) (R22) release of a deferred change
    assign apply[ch] = trig_ff[ch] & (~zc_en_ff[ch] | zc_seen |
      (timeout_en_ff & tick_rise & (tmo_cnt_ff[ch] == igc_pkg::TIMEOUT_TICKS - 2'h1)));

    // (R14) (R16) register fields and pending gain
    always_ff @(posedge core_clk) begin
      if (reg_rst) begin
        stored_ff[ch] <= igc_pkg::GAIN_RST;
        mute_ff[ch] <= igc_pkg::GAIN_REG_MUTE_RST;
        zc_en_ff[ch] <= igc_pkg::GAIN_REG_ZC_RST;
        pend_ff[ch] <= 1'b0;
      end else if (wr_gain[ch] && !alc_en_ff[ch]) begin
        stored_ff[ch] <= wr_data[igc_pkg::F_GAIN_LSB +: igc_pkg::GAIN_W];
        mute_ff[ch] <= wr_data[igc_pkg::F_MUTE];
        zc_en_ff[ch] <= wr_data[igc_pkg::F_ZC];
        pend_ff[ch] <= ~wr_data[igc_pkg::F_UPDATE];
      end else if (wr_gain[ch]) begin
        mute_ff[ch] <= wr_data[igc_pkg::F_MUTE];
        zc_en_ff[ch] <= wr_data[igc_pkg::F_ZC];
      end else if (|wr_upd) begin
        pend_ff[ch] <= 1'b0;
      end
    end

    // (R17) update triggers each channel not under level control
    always_ff @(posedge core_clk) begin
      if (reg_rst) begin
        trig_ff[ch] <= 1'b0;
        tmo_cnt_ff[ch] <= 2'h0;
      end else if ((|wr_upd) && !alc_en_ff[ch]) begin
        trig_ff[ch] <= 1'b1;
        tmo_cnt_ff[ch] <= 2'h0;
      end else if (apply[ch]) begin
        trig_ff[ch] <= 1'b0;
        tmo_cnt_ff[ch] <= 2'h0;
      end else if (trig_ff[ch] && tick_rise) begin
        tmo_cnt_ff[ch] <= tmo_cnt_ff[ch] + 2'h1;
      end
    end

    // (R18) level control drives active gain
    always_ff @(posedge core_clk) begin
      if (reg_rst) begin
        active_ff[ch] <= igc_pkg::GAIN_RST;
      end else if (alc_en_ff[ch] && alc_gain_vld[ch]) begin
        active_ff[ch] <= (ch == 0) ? alc_gain_l : alc_gain_r;
      end else if (apply[ch]) begin
        active_ff[ch] <= stored_ff[ch];
      end
    end

    // (R13) path power gate
    assign path_pass[ch] = amp_pwr_ff[ch] & boost_pwr_ff[ch] & ~mute_ff[ch];
  end

  // (R12) gain code range 0.75dB steps
  assign gain_l_out = active_ff[0];
  assign gain_r_out = active_ff[1];
  // (R23) mute independent of gain
  assign amp_mute = mute_ff;
  // (R11) source select outputs
  assign sel_l = insel_ff[0];
  assign sel_r = insel_ff[1];
  assign alc_enable = alc_en_ff;

  // readback; (R15) update bit reads zero, (R05) no reset status
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_data <= 9'h000;
    end else if (rd_stb && !int_rst) begin
      unique case (rd_addr)
        igc_pkg::ADDR_LEFT_GAIN: rd_data <= {1'b0, zc_en_ff[0], mute_ff[0], stored_ff[0]};
        igc_pkg::ADDR_RIGHT_GAIN: rd_data <= {1'b0, zc_en_ff[1], mute_ff[1], stored_ff[1]};
        igc_pkg::ADDR_ZC_TIMEOUT: rd_data <= {8'h00, timeout_en_ff};
        igc_pkg::ADDR_INPUT_POWER: rd_data <= {3'h0, boost_pwr_ff, amp_pwr_ff, 2'h0};
        igc_pkg::ADDR_LEVEL_CTRL: rd_data <= {alc_en_ff, 7'h00};
        igc_pkg::ADDR_INPUT_SELECT: rd_data <= {2'h0, insel_ff[1], 1'b0, insel_ff[0]};
        default: rd_data <= 9'h000;
      endcase
    end
  end
endmodule // igc_top

// File: test/igc_checker.sv
// concurrent checks on the input gain control top ports
module igc_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic analog_supply_ok,
  input wire logic core_supply_ok,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [6:0] wr_addr,
  input wire logic [8:0] wr_data,
  input wire logic [6:0] rd_addr,
  input wire logic [8:0] rd_data,
  input wire logic [1:0] zero_cross,
  input wire logic [5:0] gain_l_out,
  input wire logic [1:0] amp_mute,
  input wire logic [2:0] sel_l,
  input wire logic [2:0] sel_r,
  input wire logic [1:0] alc_enable
);
  logic [10:0] ok_cnt_ff;
  logic run;
  logic wl;
  assign run = ok_cnt_ff >= 11'h3F2;
  assign wl = wr_stb && wr_addr == igc_pkg::ADDR_LEFT_GAIN && run;
  // cycles since both supplies good
  always_ff @(posedge core_clk) begin
    if (rst || !(analog_supply_ok && core_supply_ok)) begin
      ok_cnt_ff <= 11'h000;
    end else if (ok_cnt_ff != 11'h7FF) begin
      ok_cnt_ff <= ok_cnt_ff + 11'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_SUPPLY_LOW: assert property ((!analog_supply_ok || !core_supply_ok)[*6]
    |-> sel_l == igc_pkg::INSEL_RST && sel_r == igc_pkg::INSEL_RST) else $error("select not default in reset");
  AST_EXT_HOLD: assert property (ok_cnt_ff != 11'h000 && ok_cnt_ff < 11'h3DE
    |-> sel_l == igc_pkg::INSEL_RST && gain_l_out == igc_pkg::GAIN_RST) else $error("state changed in extension");
  AST_SOFT_RESET: assert property (wr_stb && wr_addr == igc_pkg::ADDR_SOFT_RESET |=> ##1
    sel_l == igc_pkg::INSEL_RST && gain_l_out == igc_pkg::GAIN_RST && alc_enable == 2'h0) else $error("soft reset");
  AST_UPD_APPLY: assert property (wl && wr_data[8:7] == 2'h2 && !alc_enable[0]
    |=> ##1 gain_l_out == $past(wr_data[5:0], 2)) else $error("update write not applied");
  AST_MUTE_WR: assert property (wl |=> amp_mute[0] == $past(wr_data[6])) else $error("mute not written");
  AST_SEL_WR: assert property (wr_stb && wr_addr == igc_pkg::ADDR_INPUT_SELECT && run
    |=> {sel_r, sel_l} == {$past(wr_data[6:4]), $past(wr_data[2:0])}) else $error("select not written");
  AST_RD_NO_UPD: assert property (rd_stb && (rd_addr == igc_pkg::ADDR_LEFT_GAIN || rd_addr == igc_pkg::ADDR_RIGHT_GAIN)
    && run |=> !rd_data[8])
    else $error("update bit read back");
  AST_ZC_HOLD: assert property ((!zero_cross[0] && !alc_enable[0])[*3] ##0 (wl && wr_data[8:7] == 2'h3)
    |=> ##1 gain_l_out == $past(gain_l_out, 2)) else $error("gain changed before crossing");
  cover property (wr_stb && wr_addr == igc_pkg::ADDR_SOFT_RESET && run);
  cover property ($rose(amp_mute[0]));
  cover property (run && $changed(gain_l_out));
endmodule // igc_checker
bind igc_top igc_checker i_igc_checker (.core_clk, .rst, .analog_supply_ok, .core_supply_ok, .wr_stb, .rd_stb,
  .wr_addr, .wr_data, .rd_addr, .rd_data, .zero_cross, .gain_l_out, .amp_mute, .sel_l, .sel_r, .alc_enable);

// File: test/igc_host_model.sv
// host side model of the control access strobes
module igc_host_model (
  input wire logic core_clk,
  input wire logic [8:0] rd_data,
  output logic wr_stb = 1'b0,
  output logic rd_stb = 1'b0,
  output logic [6:0] wr_addr = 7'h00,
  output logic [8:0] wr_data = 9'h000,
  output logic [6:0] rd_addr = 7'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [6:0] a, input logic [8:0] v);
    @(posedge core_clk);
    wr_stb <= 1'b1;
    wr_addr <= a;
    wr_data <= v;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    wr_data <= ~v;
  endtask
  task automatic rd(input logic [6:0] a, output logic [8:0] v);
    @(posedge core_clk);
    rd_stb <= 1'b1;
    rd_addr <= a;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 v = rd_data;
  endtask
  task automatic wait_ready(input logic [8:0] t, output int n);
    logic [8:0] v;
    n = 0;
    v = 9'h000;
    while (v !== t && n < 1000) begin
      wr(igc_pkg::ADDR_INPUT_SELECT, t);
      rd(igc_pkg::ADDR_INPUT_SELECT, v);
      n++;
    end
  endtask
endmodule // igc_host_model

// File: test/input_gain_control_and_reset_tb.sv
// self-checking bench for the input gain control block
module input_gain_control_and_reset_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] A_L = igc_pkg::ADDR_LEFT_GAIN;
  localparam logic [6:0] A_SEL = igc_pkg::ADDR_INPUT_SELECT;
  logic core_clk, rst, analog_supply_ok, core_supply_ok, slow_tick, wr_stb, rd_stb;
  logic [6:0] wr_addr, rd_addr;
  logic [8:0] wr_data, rd_data, d;
  logic [1:0] zero_cross, alc_gain_vld, amp_mute, path_pass, alc_enable;
  logic [5:0] alc_gain_l, alc_gain_r, gain_l_out, gain_r_out;
  logic [2:0] sel_l, sel_r;
  int failures, cmp_count, n;
  igc_top i_igc_top (.core_clk, .rst, .analog_supply_ok, .core_supply_ok, .wr_stb, .rd_stb, .wr_addr, .wr_data,
    .rd_addr, .rd_data, .zero_cross, .slow_tick, .alc_gain_vld, .alc_gain_l, .alc_gain_r, .gain_l_out,
    .gain_r_out, .amp_mute, .sel_l, .sel_r, .path_pass, .alc_enable);
  igc_host_model i_igc_host_model (.core_clk, .rd_data, .wr_stb, .rd_stb, .wr_addr, .wr_data, .rd_addr);
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [6:0] a, input logic [8:0] v);
    i_igc_host_model.wr(a, v);
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic ready_chk();
    i_igc_host_model.wait_ready(9'h011, n);
    chk(12'(n > 2 && n * 4 <= igc_pkg::EXT_MAX_CYCLES + 16), 12'h001);
  endtask
  task automatic close_out();
    $display("checks=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    {analog_supply_ok, core_supply_ok, slow_tick, zero_cross, alc_gain_vld} = 7'h00;
    {alc_gain_l, alc_gain_r} = 12'h000;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    analog_supply_ok <= 1'b1;
    core_supply_ok <= 1'b1;
    w(A_SEL, 9'h044);
    chk(12'({sel_r, sel_l}), 12'h01B);
    ready_chk();
    w(igc_pkg::ADDR_SOFT_RESET, 9'h1FF);
    chk({sel_r, sel_l, gain_l_out}, {6'h1B, igc_pkg::GAIN_RST});
    for (int i = 0; i < 3; i++) begin
      w(A_SEL, 9'(9'h011 << i));
      chk(12'({sel_r, sel_l}), 12'(12'h009 << i));
    end
    for (int i = 0; i < 2; i++) begin
      w(A_L, 9'h100 + 9'(i * 63));
      chk(12'(gain_l_out), 12'(i * 63));
    end
    w(A_L, 9'h025);
    chk(12'(gain_l_out), 12'h03F);
    w(igc_pkg::ADDR_RIGHT_GAIN, 9'h11A);
    chk({gain_l_out, gain_r_out}, 12'h95A);
    i_igc_host_model.rd(igc_pkg::ADDR_RIGHT_GAIN, d);
    chk(12'(d), 12'h01A);
    w(igc_pkg::ADDR_INPUT_POWER, 9'h014);
    w(A_L, 9'h065);
    chk(12'({path_pass, amp_mute, gain_l_out}), 12'h065);
    w(A_L, 9'h025);
    chk(12'(path_pass), 12'h001);
    w(igc_pkg::ADDR_INPUT_POWER, 9'h004);
    chk(12'(path_pass), 12'h000);
    w(igc_pkg::ADDR_LEVEL_CTRL, 9'h080);
    @(posedge core_clk);
    alc_gain_l <= 6'h30;
    alc_gain_vld <= 2'h1;
    @(posedge core_clk);
    alc_gain_vld <= 2'h0;
    #1 chk(12'({alc_enable, gain_l_out}), 12'h070);
    w(igc_pkg::ADDR_LEVEL_CTRL, 9'h000);
    w(A_L, 9'h185);
    chk(12'(gain_l_out), 12'h030);
    @(posedge core_clk);
    zero_cross <= 2'h1;
    repeat (6) @(posedge core_clk);
    zero_cross <= 2'h0;
    #1 chk(12'(gain_l_out), 12'h005);
    w(igc_pkg::ADDR_ZC_TIMEOUT, 9'h001);
    w(A_L, 9'h186);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      slow_tick <= 1'b1;
      repeat (4) @(posedge core_clk);
      slow_tick <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1 chk(12'(gain_l_out), (i < 2) ? 12'h005 : 12'h006);
    end
    w(A_SEL, 9'h011);
    @(posedge core_clk);
    analog_supply_ok <= 1'b0;
    repeat (8) @(posedge core_clk);
    analog_supply_ok <= 1'b1;
    w(A_SEL, 9'h022);
    chk({sel_r, sel_l, gain_l_out}, {6'h1B, igc_pkg::GAIN_RST});
    ready_chk();
    close_out();
  end
endmodule // input_gain_control_and_reset_tb
